// File: design/cpu_regs.v
// CPU architectural registers: A, X, Y, PC, flags and stack pointer,
// with context stacking for calls and interrupts into a local stack memory.
// Assumes the execution unit issues one command at a time and waits for
// busy_o to drop before issuing the next.
`timescale 1ns/1ns
`include "cpu_regs_defs.vh"

module cpu_regs (
   input  wire        mclk_i,
   input  wire        sys_rst_i,
   // Register writes from the execution unit
   input  wire        acc_we_i,
   input  wire [7:0]  acc_d_i,
   input  wire        idx_x_we_i,
   input  wire [7:0]  idx_x_d_i,
   input  wire        idx_y_we_i,
   input  wire [7:0]  idx_y_d_i,
   input  wire        pc_we_i,
   input  wire [15:0] pc_d_i,
   input  wire        sp_low_we_i,
   input  wire [7:0]  sp_low_d_i,
   input  wire        flags_we_i,
   input  wire [7:0]  flags_d_i,
   input  wire        prio_we_i,
   input  wire [1:0]  prio_d_i,
   // Flag update from the ALU
   input  wire [2:0]  flag_op_i,
   input  wire [7:0]  op_a_i,
   input  wire [7:0]  op_b_i,
   input  wire        carry_in_i,
   input  wire [7:0]  result_i,
   input  wire        carry_out_i,
   // Stack commands
   input  wire [2:0]  stk_cmd_i,
   input  wire [1:0]  vector_prio_i,
   // Single-byte push and pop
   input  wire        push_i,
   input  wire [7:0]  push_d_i,
   input  wire        pop_i,
   // Register outputs
   output reg  [7:0]  acc_o,
   output reg  [7:0]  idx_x_o,
   output reg  [7:0]  idx_y_o,
   output reg  [15:0] program_counter_o,
   output reg  [7:0]  condition_flags_o,
   output reg  [15:0] stack_pointer_o,
   output reg  [7:0]  pop_d_o,
   output reg         pop_valid_o,
   output reg         busy_o
);

   // ---------------------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------------------
   localparam [5:0] ST_IDLE  = 6'h01;
   localparam [5:0] ST_PUSH  = 6'h02; // Context bytes going out
   localparam [5:0] ST_PREAD = 6'h04; // Address pop read
   localparam [5:0] ST_PWAIT = 6'h08; // Memory read latency
   localparam [5:0] ST_PTAKE = 6'h10; // Byte arrived
   localparam [5:0] ST_SPOP  = 6'h20; // Single pop latency

   reg  [5:0] state;
   reg  [2:0] byte_cnt;  // Bytes left in the current sequence
   reg        is_irq;    // Sequence carries full interrupt context
   reg  [7:0] sp_low;
   reg  [7:0] ctx [0:4]; // Snapshot pushed out, PROGRAM_COUNTER_LOW first
   reg        spop_pend;

   wire [7:0] next_flags;
   wire [7:0] rd_data;
   reg        mem_we;
   reg  [7:0] mem_wd;
   reg  [7:0] rd_addr;
   reg  [7:0] flags_comb;
   integer    i;

   // Wrapping stays inside the 8-bit low byte on purpose
   wire [7:0] sp_dec = sp_low - 8'h01;
   wire [7:0] sp_inc = sp_low + 8'h01;

   flag_unit u_flag_unit (
      .flag_op_i    (flag_op_i),
      .op_a_i       (op_a_i),
      .op_b_i       (op_b_i),
      .carry_in_i   (carry_in_i),
      .result_i     (result_i),
      .carry_out_i  (carry_out_i),
      .cur_flags_i  (condition_flags_o),
      .next_flags_o (next_flags)
   );

   stack_ram #(.DEPTH_LOG2(8)) u_stack_ram (
      .mclk_i    (mclk_i),
      .wr_en_i   (mem_we),
      .wr_addr_i (sp_low),
      .wr_data_i (mem_wd),
      .rd_addr_i (rd_addr),
      .rd_data_o (rd_data)
   );

   // ---------------------------------------------------------------------------
   // Stack memory steering
   // ---------------------------------------------------------------------------
   // Pushes write at the current pointer; pops read one above it
   always @* begin
      mem_we  = 1'b0;
      mem_wd  = push_d_i;
      rd_addr = (state == ST_PWAIT || state == ST_SPOP) ? sp_low : sp_inc;
      if (state == ST_PUSH) begin
         mem_we = 1'b1;
         mem_wd = is_irq ? ctx[3'd5 - byte_cnt] : ctx[3'd2 - byte_cnt];
      end else if (state == ST_IDLE && push_i) begin
         mem_we = 1'b1;
      end
   end

   // Flags presented for the next edge: fixed ones kept set
   always @* begin
      flags_comb = next_flags;
      if (flags_we_i) begin
         flags_comb = flags_d_i;
      end
      if (prio_we_i) begin
         flags_comb[`CF_PRIO_HIGH] = prio_d_i[1];
         flags_comb[`CF_PRIO_LOW]  = prio_d_i[0];
      end
      flags_comb = flags_comb | `CF_FIXED_ONES;
   end

   // ---------------------------------------------------------------------------
   // Main register and sequencer process
   // ---------------------------------------------------------------------------
   // Y register has no path here from the stack sequencer at all
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state             <= ST_IDLE;
         byte_cnt          <= 3'h0;
         is_irq            <= 1'b0;
         spop_pend         <= 1'b0;
         sp_low            <= `SP_LOW_RESET;
         stack_pointer_o   <= `SP_RESET;
         acc_o             <= 8'h00;
         idx_x_o           <= 8'h00;
         idx_y_o           <= 8'h00;
         program_counter_o <= 16'h0000;
         condition_flags_o <= `CF_RESET;
         pop_d_o           <= 8'h00;
         pop_valid_o       <= 1'b0;
         busy_o            <= 1'b0;
         for (i = 0; i < 5; i = i + 1) begin
            ctx[i] <= 8'h00;
         end
      end else begin
         pop_valid_o <= 1'b0;
         if (idx_y_we_i) begin
            idx_y_o <= idx_y_d_i;
         end
         case (state)
            ST_IDLE: begin
               if (acc_we_i) begin
                  acc_o <= acc_d_i;
               end
               if (idx_x_we_i) begin
                  idx_x_o <= idx_x_d_i;
               end
               if (pc_we_i) begin
                  program_counter_o <= pc_d_i;
               end
               condition_flags_o <= flags_comb;
               if (sp_low_we_i) begin
                  sp_low          <= sp_low_d_i;
                  stack_pointer_o <= {`SP_PAGE, sp_low_d_i};
               end
               case (stk_cmd_i)
                  `STK_IRQ: begin
                     ctx[0]   <= program_counter_o[7:0];
                     ctx[1]   <= program_counter_o[15:8];
                     ctx[2]   <= idx_x_o;
                     ctx[3]   <= acc_o;
                     ctx[4]   <= condition_flags_o;
                     byte_cnt <= 3'h5;
                     is_irq   <= 1'b1;
                     state    <= ST_PUSH;
                     busy_o   <= 1'b1;
                     // New level from the serviced vector
                     condition_flags_o[`CF_PRIO_HIGH] <= vector_prio_i[1];
                     condition_flags_o[`CF_PRIO_LOW]  <= vector_prio_i[0];
                  end
                  `STK_CALL: begin
                     ctx[0]   <= program_counter_o[7:0];
                     ctx[1]   <= program_counter_o[15:8];
                     byte_cnt <= 3'h2;
                     is_irq   <= 1'b0;
                     state    <= ST_PUSH;
                     busy_o   <= 1'b1;
                  end
                  `STK_IRQ_RETURN_INSTR: begin
                     byte_cnt <= 3'h5;
                     is_irq   <= 1'b1;
                     state    <= ST_PREAD;
                     busy_o   <= 1'b1;
                  end
                  `STK_RET: begin
                     byte_cnt <= 3'h2;
                     is_irq   <= 1'b0;
                     state    <= ST_PREAD;
                     busy_o   <= 1'b1;
                  end
                  `STK_RSP: begin
                     sp_low          <= `SP_LOW_RESET;
                     stack_pointer_o <= `SP_RESET;
                  end
                  default: begin
                     if (push_i) begin
                        sp_low          <= sp_dec;
                        stack_pointer_o <= {`SP_PAGE, sp_dec};
                     end else if (pop_i) begin
                        sp_low          <= sp_inc;
                        stack_pointer_o <= {`SP_PAGE, sp_inc};
                        state           <= ST_SPOP;
                        spop_pend       <= 1'b1;
                        busy_o          <= 1'b1;
                     end
                  end
               endcase
            end
            ST_PUSH: begin
               // Byte written this edge, then step down
               sp_low          <= sp_dec;
               stack_pointer_o <= {`SP_PAGE, sp_dec};
               byte_cnt        <= byte_cnt - 3'h1;
               if (byte_cnt == 3'h1) begin
                  state  <= ST_IDLE;
                  busy_o <= 1'b0;
               end
            end
            ST_PREAD: begin
               // Increment before reading: the read address is sp+1
               sp_low          <= sp_inc;
               stack_pointer_o <= {`SP_PAGE, sp_inc};
               state           <= ST_PWAIT;
            end
            ST_PWAIT: begin
               state <= ST_PTAKE;
            end
            ST_PTAKE: begin
               // Reverse of the push order: flags, A, X, PROGRAM_COUNTER_HIGH, PROGRAM_COUNTER_LOW
               if (is_irq) begin
                  case (byte_cnt)
                     3'h5: condition_flags_o <= rd_data | `CF_FIXED_ONES;
                     3'h4: acc_o <= rd_data;
                     3'h3: idx_x_o <= rd_data;
                     3'h2: program_counter_o[15:8] <= rd_data;
                     default: program_counter_o[7:0] <= rd_data;
                  endcase
               end else begin
                  if (byte_cnt == 3'h2) begin
                     program_counter_o[15:8] <= rd_data;
                  end else begin
                     program_counter_o[7:0] <= rd_data;
                  end
               end
               byte_cnt <= byte_cnt - 3'h1;
               if (byte_cnt == 3'h1) begin
                  state  <= ST_IDLE;
                  busy_o <= 1'b0;
               end else begin
                  state <= ST_PREAD;
               end
            end
            ST_SPOP: begin
               // Read issued at old sp+1 on the pop edge; first cycle here waits, data taken on the second
               if (spop_pend) begin
                  spop_pend <= 1'b0;
               end else begin
                  pop_d_o     <= rd_data;
                  pop_valid_o <= 1'b1;
                  state       <= ST_IDLE;
                  busy_o      <= 1'b0;
               end
            end
            default: begin
               state  <= ST_IDLE;
               busy_o <= 1'b0;
            end
         endcase
      end
   end

endmodule // cpu_regs

// File: design/cpu_regs_defs.vh
// Constants for the CPU architectural register file.
// Assumes a single clock domain and synchronous reset.
`ifndef CPU_REGS_DEFS_VH
`define CPU_REGS_DEFS_VH

// -----------------------------------------------------------------------------
// Flag register fields
// -----------------------------------------------------------------------------
`define CF_CARRY      0
`define CF_ZERO       1
`define CF_NEG        2
`define CF_PRIO_LOW   3
`define CF_HALF       4
`define CF_PRIO_HIGH  5
`define CF_RESET      8'hEA
`define CF_FIXED_ONES 8'hC0

// -----------------------------------------------------------------------------
// Priority encodings {high,low}
// -----------------------------------------------------------------------------
`define PRIO_MAIN     2'h2
`define PRIO_LEVEL1   2'h1
`define PRIO_LEVEL2   2'h0
`define PRIO_DISABLE  2'h3

// -----------------------------------------------------------------------------
// Stack pointer
// -----------------------------------------------------------------------------
`define SP_PAGE       8'h01
`define SP_LOW_RESET  8'hFF
`define SP_RESET      16'h01FF

// -----------------------------------------------------------------------------
// Flag update selects (flag_op_i)
// -----------------------------------------------------------------------------
`define FOP_NONE      3'h0
`define FOP_ADD       3'h1
`define FOP_ARITH     3'h2
`define FOP_LOGIC     3'h3
`define FOP_CARRY     3'h4
`define FOP_SCF       3'h5
`define FOP_RCF       3'h6

// -----------------------------------------------------------------------------
// Stack commands (stk_cmd_i)
// -----------------------------------------------------------------------------
`define STK_NONE      3'h0
`define STK_IRQ       3'h1
`define STK_IRQ_RETURN_INSTR      3'h2
`define STK_CALL      3'h3
`define STK_RET       3'h4
`define STK_RSP       3'h5

`endif

// File: design/flag_unit.v
// Combinational next-value logic for the arithmetic flags.
// Assumes the execution unit supplies operands, result and carry-out.
`timescale 1ns/1ns
`include "cpu_regs_defs.vh"

module flag_unit (
   input  wire [2:0] flag_op_i,
   input  wire [7:0] op_a_i,
   input  wire [7:0] op_b_i,
   input  wire       carry_in_i,
   input  wire [7:0] result_i,
   input  wire       carry_out_i,
   input  wire [7:0] cur_flags_i,
   output reg  [7:0] next_flags_o
);

   wire [4:0] low_sum;

   // Nibble add reproduces the carry from bit 3 into bit 4
   assign low_sum = {1'b0, op_a_i[3:0]} + {1'b0, op_b_i[3:0]} + {4'h0, carry_in_i};

   // ---------------------------------------------------------------------------
   // Flag selection
   // ---------------------------------------------------------------------------
   // Each op updates only its own flags; the rest hold
   always @* begin
      next_flags_o = cur_flags_i;
      case (flag_op_i)
         `FOP_ADD: begin
            next_flags_o[`CF_HALF]  = low_sum[4];
            next_flags_o[`CF_NEG]   = result_i[7];
            next_flags_o[`CF_ZERO]  = (result_i == 8'h00);
            next_flags_o[`CF_CARRY] = carry_out_i;
         end
         `FOP_ARITH: begin
            next_flags_o[`CF_NEG]   = result_i[7];
            next_flags_o[`CF_ZERO]  = (result_i == 8'h00);
            next_flags_o[`CF_CARRY] = carry_out_i;
         end
         `FOP_LOGIC: begin
            next_flags_o[`CF_NEG]   = result_i[7];
            next_flags_o[`CF_ZERO]  = (result_i == 8'h00);
         end
         `FOP_CARRY: next_flags_o[`CF_CARRY] = carry_out_i;
         `FOP_SCF:   next_flags_o[`CF_CARRY] = 1'b1;
         `FOP_RCF:   next_flags_o[`CF_CARRY] = 1'b0;
         default:    next_flags_o = cur_flags_i;
      endcase
   end

endmodule // flag_unit

// File: design/stack_ram.v
// Little 256-byte stack memory with registered read data.
// Assumes one write and one read port on the same clock.
`timescale 1ns/1ns

module stack_ram #(
   parameter DEPTH_LOG2 = 8
) (
   input  wire                  mclk_i,
   input  wire                  wr_en_i,
   input  wire [DEPTH_LOG2-1:0] wr_addr_i,
   input  wire [7:0]            wr_data_i,
   input  wire [DEPTH_LOG2-1:0] rd_addr_i,
   output reg  [7:0]            rd_data_o
);

   reg [7:0] mem [0:(1<<DEPTH_LOG2)-1];

   // Write-first not needed: push and pop never overlap
   always @(posedge mclk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem[rd_addr_i];
   end

endmodule // stack_ram

// File: dv/alu_model.sv
// Execution unit ALU stand-in that feeds result and carry to the flags.
// Assumes the bench selects add or subtract and holds operands steady.
`timescale 1ns/1ns

module alu_model (
   input  wire logic [7:0] a_i,
   input  wire logic [7:0] b_i,
   input  wire logic       cin_i,
   input  wire logic       sub_i,
   output logic      [7:0] res_o,
   output logic            cout_o
);
   // Nine-bit sum or difference; the top bit is carry or borrow
   assign {cout_o, res_o} = sub_i ? {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i}
                                  : {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
endmodule // alu_model

// File: dv/cpu_regs_monitor.sv
// Port checker for the CPU register file.
// Assumes binding onto cpu_regs; one clock, synchronous active high reset.
`timescale 1ns/1ns
`include "cpu_regs_defs.vh"

module cpu_regs_monitor (
   input wire logic        mclk_i,
   input wire logic        sys_rst_i,
   input wire logic        flags_we_i,
   input wire logic        prio_we_i,
   input wire logic        idx_y_we_i,
   input wire logic [2:0]  flag_op_i,
   input wire logic [7:0]  op_a_i,
   input wire logic [7:0]  op_b_i,
   input wire logic        carry_in_i,
   input wire logic [7:0]  result_i,
   input wire logic        carry_out_i,
   input wire logic [2:0]  stk_cmd_i,
   input wire logic [1:0]  vector_prio_i,
   input wire logic        push_i,
   input wire logic        pop_i,
   input wire logic [7:0]  idx_y_o,
   input wire logic [7:0]  condition_flags_o,
   input wire logic [15:0] stack_pointer_o,
   input wire logic        pop_valid_o,
   input wire logic        busy_o
);
   // ------------
   // Helpers
   // ------------
   logic [7:0] sp_take;
   wire idle = !busy_o;
   wire half = ({1'b0, op_a_i[3:0]} + {1'b0, op_b_i[3:0]} + {4'h0, carry_in_i}) > 5'h0F;
   // Flag ops only count when nothing else writes the flag register
   wire fop  = idle && !flags_we_i && !prio_we_i && stk_cmd_i == `STK_NONE;

   // Pointer frozen while busy, so it still shows the value at the take edge
   always @(posedge mclk_i) begin
      if (idle)
         sp_take <= stack_pointer_o[7:0];
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   // ------------
   // Sequences and assertions
   // ------------
   sequence s_irq_busy;
      busy_o [*5] ##1 !busy_o;
   endsequence
   sequence s_pop_wait;
      busy_o ##1 busy_o ##1 pop_valid_o;
   endsequence

   a_reset_values: assert property ($past(sys_rst_i) |->
      condition_flags_o == `CF_RESET && stack_pointer_o == `SP_RESET && !busy_o)
      else $error("reset values wrong");
   a_sp_page: assert property (stack_pointer_o[15:8] == `SP_PAGE)
      else $error("stack page moved");
   a_irq_entry: assert property (idle && stk_cmd_i == `STK_IRQ |=>
      {condition_flags_o[5], condition_flags_o[3]} == $past(vector_prio_i) ##0 s_irq_busy
      ##0 stack_pointer_o[7:0] == sp_take - 8'h05)
      else $error("interrupt entry wrong");
   a_y_untouched: assert property (idle && stk_cmd_i inside {`STK_IRQ, `STK_IRQ_RETURN_INSTR}
      && !idx_y_we_i |=> ($stable(idx_y_o) || $past(idx_y_we_i)) [*8])
      else $error("second index changed by context");
   a_call_two: assert property (idle && stk_cmd_i == `STK_CALL |->
      ##[1:4] (!busy_o && stack_pointer_o[7:0] == sp_take - 8'h02))
      else $error("call stack use wrong");
   a_rsp_load: assert property (idle && stk_cmd_i == `STK_RSP |=>
      stack_pointer_o == `SP_RESET)
      else $error("stack reset wrong");
   a_push_dec: assert property (idle && push_i && stk_cmd_i == `STK_NONE |=>
      stack_pointer_o[7:0] == $past(stack_pointer_o[7:0]) - 8'h01)
      else $error("push pointer wrong");
   a_pop_inc: assert property (idle && pop_i && !push_i && stk_cmd_i == `STK_NONE |=>
      stack_pointer_o[7:0] == $past(stack_pointer_o[7:0]) + 8'h01 ##0 s_pop_wait)
      else $error("pop pointer or timing wrong");
   a_add_flags: assert property (fop && flag_op_i == `FOP_ADD |=>
      condition_flags_o[4] == $past(half) && condition_flags_o[2:0] ==
      {$past(result_i[7]), $past(result_i) == 8'h00, $past(carry_out_i)})
      else $error("add flags wrong");
   a_logic_flags: assert property (fop && flag_op_i == `FOP_LOGIC |=>
      condition_flags_o[2:1] == {$past(result_i[7]), $past(result_i) == 8'h00}
      && condition_flags_o[0] == $past(condition_flags_o[0]))
      else $error("logic flags wrong");
   a_carry_cmds: assert property (fop && flag_op_i inside {`FOP_SCF, `FOP_RCF} |=>
      condition_flags_o[0] == ($past(flag_op_i) == `FOP_SCF))
      else $error("carry command wrong");
endmodule // cpu_regs_monitor

// File: dv/test_cpu_regs.sv
// Self-checking bench for the CPU register file, random plus corner cases.
// Assumes design/ on the include path; the checker is bound below.
`timescale 1ns/1ns
`include "cpu_regs_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module test_cpu_regs;
   logic        mclk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        acc_we_i, idx_x_we_i, idx_y_we_i, pc_we_i, sp_low_we_i, flags_we_i, prio_we_i;
   logic [7:0]  acc_d_i, idx_x_d_i, idx_y_d_i, sp_low_d_i, flags_d_i, push_d_i, op_a_i, op_b_i;
   logic [15:0] pc_d_i;
   logic [2:0]  flag_op_i, stk_cmd_i;
   logic [1:0]  prio_d_i, vector_prio_i;
   logic        carry_in_i, push_i, pop_i, sub_sel;
   wire  [7:0]  result_i, acc_o, idx_x_o, idx_y_o, condition_flags_o, pop_d_o;
   wire         carry_out_i, pop_valid_o, busy_o;
   wire  [15:0] program_counter_o, stack_pointer_o;
   int          mismatches = 0;
   int          n_tests = 0;
   logic [31:0] seed = 32'h54F6;

   cpu_regs dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .acc_we_i(acc_we_i),
      .acc_d_i(acc_d_i), .idx_x_we_i(idx_x_we_i), .idx_x_d_i(idx_x_d_i),
      .idx_y_we_i(idx_y_we_i), .idx_y_d_i(idx_y_d_i), .pc_we_i(pc_we_i), .pc_d_i(pc_d_i),
      .sp_low_we_i(sp_low_we_i), .sp_low_d_i(sp_low_d_i), .flags_we_i(flags_we_i),
      .flags_d_i(flags_d_i), .prio_we_i(prio_we_i), .prio_d_i(prio_d_i),
      .flag_op_i(flag_op_i), .op_a_i(op_a_i), .op_b_i(op_b_i), .carry_in_i(carry_in_i),
      .result_i(result_i), .carry_out_i(carry_out_i), .stk_cmd_i(stk_cmd_i),
      .vector_prio_i(vector_prio_i), .push_i(push_i), .push_d_i(push_d_i), .pop_i(pop_i),
      .acc_o(acc_o), .idx_x_o(idx_x_o), .idx_y_o(idx_y_o),
      .program_counter_o(program_counter_o), .condition_flags_o(condition_flags_o),
      .stack_pointer_o(stack_pointer_o), .pop_d_o(pop_d_o), .pop_valid_o(pop_valid_o),
      .busy_o(busy_o));
   alu_model u_alu (.a_i(op_a_i), .b_i(op_b_i), .cin_i(carry_in_i), .sub_i(sub_sel),
      .res_o(result_i), .cout_o(carry_out_i));

   // 100 MHz clock
   always #5 mclk_i = ~mclk_i;

   // ------------
   // Helpers
   // ------------
   function logic [7:0] r8();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   // Expected {H,N,Z,C} worked out independently of the ALU model
   function logic [3:0] exp_flags(input logic [2:0] op, input logic [7:0] a, b, input logic c);
      logic [8:0] s;
      s = (op == `FOP_ARITH) ? {1'b0, a} - {1'b0, b} - {8'h00, c}
                             : {1'b0, a} + {1'b0, b} + {8'h00, c};
      return {({1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c}) > 5'h0F, s[7], s[7:0] == 8'h00, s[8]};
   endfunction
   task tick;
      @(negedge mclk_i);
   endtask
   // Bounded wait; a hang shows up as busy still high
   task automatic cmd(input logic [2:0] c);
      int k = 0;
      stk_cmd_i = c;
      tick;
      stk_cmd_i = `STK_NONE;
      while (busy_o !== 1'b0 && k < 40) begin
         tick;
         k++;
      end
      `CHK(busy_o, 1'b0)
   endtask
   task push(input logic [7:0] d);
      push_i = 1'b1;
      push_d_i = d;
      tick;
      push_i = 1'b0;
   endtask
   task automatic pop(output logic [7:0] d);
      int k = 0;
      pop_i = 1'b1;
      tick;
      pop_i = 1'b0;
      while (pop_valid_o !== 1'b1 && k < 10) begin
         tick;
         k++;
      end
      `CHK(pop_valid_o, 1'b1)
      d = pop_d_o;
   endtask
   task setregs(input logic [7:0] a, x, y, s, f, input logic [15:0] pc);
      {acc_d_i, idx_x_d_i, idx_y_d_i, sp_low_d_i, flags_d_i, pc_d_i} = {a, x, y, s, f, pc};
      {acc_we_i, idx_x_we_i, idx_y_we_i, sp_low_we_i, flags_we_i, pc_we_i} = 6'h3F;
      tick;
      {acc_we_i, idx_x_we_i, idx_y_we_i, sp_low_we_i, flags_we_i, pc_we_i} = 6'h00;
   endtask
   task alu(input logic [2:0] op, input logic [7:0] a, b, input logic c);
      {flag_op_i, op_a_i, op_b_i, carry_in_i, sub_sel} = {op, a, b, c, op == `FOP_ARITH};
      tick;
      flag_op_i = `FOP_NONE;
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ------------
   // Main sequence
   // ------------
   initial begin
      logic [7:0] a, b, x, y, f, d;
      logic [15:0] pc;
      logic [2:0] op;
      logic [3:0] e;
      logic [39:0] ctx;
      {acc_we_i, idx_x_we_i, idx_y_we_i, pc_we_i, sp_low_we_i, flags_we_i, prio_we_i} = '0;
      {acc_d_i, idx_x_d_i, idx_y_d_i, sp_low_d_i, flags_d_i, push_d_i, op_a_i, op_b_i} = '0;
      {pc_d_i, flag_op_i, stk_cmd_i, prio_d_i, vector_prio_i} = '0;
      {carry_in_i, push_i, pop_i, sub_sel} = '0;
      repeat (12) tick;
      sys_rst_i = 1'b0;
      tick;
      `CHK(condition_flags_o, `CF_RESET)
      `CHK(stack_pointer_o, `SP_RESET)
      $display("reset test done");
      // Random flag traffic; first cases hit half carry, borrow, zero with carry
      for (int i = 0; i < 48; i++) begin
         a = r8();
         b = r8();
         op = 3'(1 + i % 3);
         case (i)
            0: {a, b} = 16'h0F01;
            1: {a, b} = 16'h0001;
            3: {a, b} = 16'hFF01;
            default: ;
         endcase
         alu(op, a, b, seed[9] & (i > 3));
         e = exp_flags(op, a, b, carry_in_i);
         if (op == `FOP_ADD)
            `CHK({condition_flags_o[4], condition_flags_o[2:0]}, e)
         else if (op == `FOP_ARITH)
            `CHK(condition_flags_o[2:0], e[2:0])
         else
            `CHK(condition_flags_o[2:1], e[2:1])
      end
      alu(`FOP_SCF, 8'h00, 8'h00, 1'b0);
      `CHK(condition_flags_o[0], 1'b1)
      alu(`FOP_RCF, 8'h00, 8'h00, 1'b0);
      `CHK(condition_flags_o[0], 1'b0)
      alu(`FOP_CARRY, 8'hFF, 8'h01, 1'b0);
      `CHK(condition_flags_o[0], 1'b1)
      for (int p = 0; p < 4; p++) begin
         prio_d_i = 2'(p);
         prio_we_i = 1'b1;
         tick;
         prio_we_i = 1'b0;
         `CHK({condition_flags_o[5], condition_flags_o[3]}, 2'(p))
      end
      flags_d_i = 8'h15;
      flags_we_i = 1'b1;
      tick;
      flags_we_i = 1'b0;
      `CHK(condition_flags_o, 8'hD5)
      $display("flag test done");
      // Push and pop, then the same across the bottom of the stack
      d = r8();
      push(d);
      `CHK(stack_pointer_o, 16'h01FE)
      pop(b);
      `CHK(b, d)
      sp_low_d_i = 8'h00;
      sp_low_we_i = 1'b1;
      tick;
      sp_low_we_i = 1'b0;
      `CHK(stack_pointer_o, 16'h0100)
      push(d);
      `CHK(stack_pointer_o, 16'h01FF)
      pop(b);
      `CHK({b, stack_pointer_o}, {d, 16'h0100})
      $display("stack test done");
      // Interrupt entry wrapping the pointer; unstack by hand, then by return
      for (int n = 0; n < 2; n++) begin
         {a, x, y, f, pc} = {r8(), r8(), r8(), r8(), r8(), r8()};
         setregs(a, x, y, 8'h02, f, pc);
         vector_prio_i = 2'(n + 1);
         cmd(`STK_IRQ);
         `CHK(stack_pointer_o, 16'h01FD)
         `CHK({condition_flags_o[5], condition_flags_o[3]}, 2'(n + 1))
         `CHK(idx_y_o, y)
         ctx = {f | 8'hC0, a, x, pc};
         if (n == 0) begin
            for (int j = 0; j < 5; j++) begin
               pop(d);
               `CHK(d, ctx[39 - 8 * j -: 8])
            end
         end else begin
            setregs(~a, ~x, y, 8'hFD, 8'h00, ~pc);
            cmd(`STK_IRQ_RETURN_INSTR);
            `CHK({condition_flags_o, acc_o, idx_x_o, program_counter_o}, ctx)
            `CHK({idx_y_o, stack_pointer_o}, {y, 16'h0102})
         end
      end
      setregs(a, x, y, 8'h80, f, pc);
      cmd(`STK_CALL);
      `CHK(stack_pointer_o, 16'h017E)
      pop(d);
      `CHK(d, pc[15:8])
      pop(d);
      `CHK(d, pc[7:0])
      setregs(a, x, y, 8'h7E, f, ~pc);
      cmd(`STK_RET);
      `CHK({program_counter_o, stack_pointer_o}, {pc, 16'h0180})
      cmd(`STK_RSP);
      `CHK(stack_pointer_o, `SP_RESET)
      $display("context test done");
      // Second reset in mid-run
      setregs(a, x, y, 8'h40, f, pc);
      sys_rst_i = 1'b1;
      tick;
      sys_rst_i = 1'b0;
      tick;
      `CHK({stack_pointer_o, condition_flags_o}, {`SP_RESET, `CF_RESET})
      $display("reset again test done");
      test_done;
   end

   // Watchdog: the tests take well under a thousand cycles
   initial begin
      #200000;
      mismatches++;
      test_done;
   end
endmodule // test_cpu_regs

bind cpu_regs cpu_regs_monitor u_mon (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
   .flags_we_i(flags_we_i), .prio_we_i(prio_we_i), .idx_y_we_i(idx_y_we_i),
   .flag_op_i(flag_op_i), .op_a_i(op_a_i), .op_b_i(op_b_i), .carry_in_i(carry_in_i),
   .result_i(result_i), .carry_out_i(carry_out_i), .stk_cmd_i(stk_cmd_i),
   .vector_prio_i(vector_prio_i), .push_i(push_i), .pop_i(pop_i), .idx_y_o(idx_y_o),
   .condition_flags_o(condition_flags_o), .stack_pointer_o(stack_pointer_o),
   .pop_valid_o(pop_valid_o), .busy_o(busy_o));
